// ### design/spas_consts.svh
/*
  Register offsets, field positions and fixed codes for the
  secure page add sequencer. Assumes a 32-bit APB with byte addresses.
*/
`ifndef SPAS_CONSTS_SVH
`define SPAS_CONSTS_SVH

`define SPAS_CTRL 8'h00
`define SPAS_STATUS 8'h04
`define SPAS_FAULT_ADDR 8'h08
`define SPAS_DESC_ADDR 8'h0c
`define SPAS_TARGET_ADDR 8'h10
`define SPAS_SRC_ADDR 8'h14
`define SPAS_CTL_ADDR 8'h18
`define SPAS_SINFO_ADDR 8'h1c
`define SPAS_LIN_ADDR 8'h20
`define SPAS_SINFO 8'h24
`define SPAS_ENV 8'h28
`define SPAS_BASE 8'h2c
`define SPAS_SIZE 8'h30
`define SPAS_LIMITS 8'h34
`define SPAS_CONTENT 8'h38
`define SPAS_TOKEN_LO 8'h3c
`define SPAS_TOKEN_HI 8'h40
`define SPAS_COUNT 8'h44

// security info field layout
`define SPAS_SI_R 0
`define SPAS_SI_W 1
`define SPAS_SI_X 2
`define SPAS_SI_PT_LO 8
`define SPAS_SI_RSVD 16

// environment register field layout
`define SPAS_ENV_SS_CAP 0
`define SPAS_ENV_SS_EN 1
`define SPAS_ENV_VIRT 2
`define SPAS_ENV_SS_SUP 3
`define SPAS_ENV_IN_USE 4
`define SPAS_ENV_TGT_VALID 5
`define SPAS_ENV_CTL_BUSY 6
`define SPAS_ENV_CTL_VALID 7
`define SPAS_ENV_MEAS_BUSY 8
`define SPAS_ENV_INIT 9
`define SPAS_ENV_WIDE 10
`define SPAS_ENV_TGT_IN_PPC 11
`define SPAS_ENV_CTL_IN_PPC 12
`define SPAS_ENV_CTL_PT_LO 24

// content flag layout
`define SPAS_CT_THREAD_RSVD 0
`define SPAS_CT_PREV_SSP 1
`define SPAS_CT_SS_LOW 2

// page types
`define SPAS_PT_CONTROL 8'h00
`define SPAS_PT_THREAD 8'h01
`define SPAS_PT_REGULAR 8'h02
`define SPAS_TYPE_SHADOW_FIRST 8'h04
`define SPAS_TYPE_SHADOW_REST 8'h05

`define SPAS_PAGE 32'h00001000
`define SPAS_LIMIT_ONES 12'hfff
`define SPAS_HASH_TAG 64'h0000000044444145
`define SPAS_CONFLICT_QUAL 16'h0001
`define SPAS_EXIT_ERROR 16'h0000

`endif

// ### design/spas_pkg.sv
/*
  Types shared by the secure page add sequencer.
  Assumes spas_consts.svh holds all numeric constants.
*/
package spas_pkg;
  typedef enum logic [1:0] {
    FK_NONE,
    FK_PROT,
    FK_PAGING,
    FK_EXIT
  } spas_fault_t;

  typedef enum logic [2:0] {
    S_IDLE,
    S_CHECK,
    S_COPY,
    S_COMMIT,
    S_DONE
  } spas_state_t;
endpackage

// ### design/spas_sequencer.sv
/*
  Secure page add sequencer: operands are loaded over APB, start runs all
  checks in one cycle, then copies the page, extends the digest and writes
  the page map entry. Assumes a copy engine on ref_clk that answers copy_req
  with copy_done, and that environment state is loaded before start.
*/
// The implementer's own choices: the register addresses and the APB register port.
// Overview of operation
// - unaligned 32-byte descriptor address: protection fault
// - unaligned 4 KB target address: protection fault
// - target or control page outside cache: paging fault
// - source, control, linear 4KB; info 64B aligned
// - reserved info bits or bad type fault
// - shadow types need shadow-stack enable set
// - busy target: fault, or hypervisor exit
// - target map entry already valid: paging fault
// - control page conflict with add/extend/init: fault
// - control map invalid or wrong type: paging
// - copy whole source page into target
// - thread page content checks
// - regular page: write without read faults
// - no shadow page on first/last range page
// - shadow page lower bytes must be zero
// - shadow page top eight bytes checked
// - shadow page needs read, write, no execute
// - linear address outside enclave range faults
// - measurement busy or enclave initialized faults
// - thread page: clear permissions and fields
// - hash block into digest, bump counter
// - commit page map entry, set valid
`timescale 1ns/10ps
`include "spas_consts.svh"

module spas_sequencer (
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic copy_done,
  output logic copy_req,
  output logic [31:0] copy_src,
  output logic [31:0] copy_dst,
  output logic thread_clear,
  output logic hash_valid,
  output logic [511:0] hash_block,
  output logic map_we,
  output logic [31:0] map_lin_addr,
  output logic [31:0] map_owner,
  output logic [7:0] map_type,
  output logic [2:0] map_rwx,
  output logic exit_req,
  output logic [15:0] exit_qual,
  output logic [15:0] exit_error,
  output logic [31:0] exit_gla
);
  spas_pkg::spas_state_t state, next_state;
  spas_pkg::spas_fault_t kind, next_kind, ck_kind;
  logic done, next_done;
  logic [31:0] fault_addr, next_fault_addr, ck_addr;
  logic [31:0] desc, target, src, ctl, sinfo_addr, lin, sinfo, env, base, size;
  logic [31:0] limits, content, token_lo, token_hi, count;
  logic [31:0] next_desc, next_target, next_src, next_ctl, next_sinfo_addr, next_lin;
  logic [31:0] next_sinfo, next_env, next_base, next_size, next_limits, next_content;
  logic [31:0] next_token_lo, next_token_hi, next_count;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;
  logic next_copy_req, next_thread_clear, next_hash_valid, next_map_we, next_exit_req;
  logic [511:0] next_hash_block;
  logic [2:0] next_map_rwx;
  logic [7:0] pt, ctl_pt;
  logic [2:0] rwx;
  logic is_ss;
  logic [32:0] range_end;
  logic [31:0] last_page, token_exp;
  logic wr, rd, mapped;

  assign pt = sinfo[`SPAS_SI_PT_LO +: 8];
  assign ctl_pt = env[`SPAS_ENV_CTL_PT_LO +: 8];
  assign rwx = {sinfo[`SPAS_SI_X], sinfo[`SPAS_SI_W], sinfo[`SPAS_SI_R]};
  assign is_ss = (pt == `SPAS_TYPE_SHADOW_FIRST) || (pt == `SPAS_TYPE_SHADOW_REST);
  assign range_end = {1'b0, base} + {1'b0, size};
  assign last_page = base + size - `SPAS_PAGE;
  assign token_exp = (lin + `SPAS_PAGE) | {31'h0, env[`SPAS_ENV_WIDE]};
  assign wr = psel && penable && pready && pwrite;
  assign rd = psel && !penable && !pwrite;

  // all checks in fixed priority order; first hit decides the fault
  always_comb begin
    ck_kind = spas_pkg::FK_NONE;
    ck_addr = 32'h0;
    if (desc[4:0] != 5'h0) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (target[11:0] != 12'h0) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (!env[`SPAS_ENV_TGT_IN_PPC]) begin
      ck_kind = spas_pkg::FK_PAGING;
      ck_addr = target;
    end else if (src[11:0] != 12'h0 || ctl[11:0] != 12'h0 || sinfo_addr[5:0] != 6'h0
                 || lin[11:0] != 12'h0) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (!env[`SPAS_ENV_CTL_IN_PPC]) begin
      ck_kind = spas_pkg::FK_PAGING;
      ck_addr = ctl;
    end else if (sinfo[`SPAS_SI_RSVD] || !(pt == `SPAS_PT_REGULAR || pt == `SPAS_PT_THREAD
                 || (is_ss && env[`SPAS_ENV_SS_CAP]))) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (is_ss && !env[`SPAS_ENV_SS_EN]) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (env[`SPAS_ENV_IN_USE]) begin
      ck_kind = env[`SPAS_ENV_VIRT] ? spas_pkg::FK_EXIT : spas_pkg::FK_PROT;
      ck_addr = target;
    end else if (env[`SPAS_ENV_TGT_VALID]) begin
      ck_kind = spas_pkg::FK_PAGING;
      ck_addr = target;
    end else if (env[`SPAS_ENV_CTL_BUSY]) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (!env[`SPAS_ENV_CTL_VALID] || ctl_pt != `SPAS_PT_CONTROL) begin
      ck_kind = spas_pkg::FK_PAGING;
      ck_addr = ctl;
    end else if (pt == `SPAS_PT_THREAD && (content[`SPAS_CT_THREAD_RSVD]
                 || (!env[`SPAS_ENV_WIDE] && (limits[11:0] != `SPAS_LIMIT_ONES
                 || limits[27:16] != `SPAS_LIMIT_ONES))
                 || (env[`SPAS_ENV_SS_SUP] && content[`SPAS_CT_PREV_SSP]))) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (pt == `SPAS_PT_REGULAR && rwx[1] && !rwx[0]) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (is_ss && (lin == base || lin == last_page)) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (is_ss && content[`SPAS_CT_SS_LOW]) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if ((pt == `SPAS_TYPE_SHADOW_FIRST && (token_lo != token_exp || token_hi != 32'h0))
                 || (pt == `SPAS_TYPE_SHADOW_REST && (token_lo != 32'h0 || token_hi != 32'h0))) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (is_ss && rwx != 3'b011) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (lin < base || {1'b0, lin} >= range_end) begin
      ck_kind = spas_pkg::FK_PROT;
    end else if (env[`SPAS_ENV_MEAS_BUSY] || env[`SPAS_ENV_INIT]) begin
      ck_kind = spas_pkg::FK_PROT;
    end
  end

  // sequencer next state; operand registers are frozen while busy
  always_comb begin
    next_state = state;
    next_kind = kind;
    next_done = done;
    next_fault_addr = fault_addr;
    next_count = count;
    next_copy_req = 1'b0;
    next_thread_clear = 1'b0;
    next_hash_valid = 1'b0;
    next_map_we = 1'b0;
    next_exit_req = 1'b0;
    next_hash_block = hash_block;
    next_map_rwx = map_rwx;
    case (state)
      spas_pkg::S_IDLE, spas_pkg::S_DONE: begin
        if (wr && paddr == `SPAS_CTRL && pwdata[0]) begin
          next_state = spas_pkg::S_CHECK;
          next_done = 1'b0;
          next_kind = spas_pkg::FK_NONE;
          next_fault_addr = 32'h0;
        end
      end
      spas_pkg::S_CHECK: begin
        if (ck_kind != spas_pkg::FK_NONE) begin
          // nothing is copied, hashed or committed on a failed check
          next_state = spas_pkg::S_DONE;
          next_done = 1'b1;
          next_kind = ck_kind;
          next_fault_addr = ck_addr;
          next_exit_req = (ck_kind == spas_pkg::FK_EXIT);
        end else begin
          next_state = spas_pkg::S_COPY;
          next_copy_req = 1'b1;
        end
      end
      spas_pkg::S_COPY: begin
        if (copy_done) begin
          next_state = spas_pkg::S_COMMIT;
        end
      end
      spas_pkg::S_COMMIT: begin
        // thread pages lose all permissions before being hashed and mapped
        next_map_rwx = (pt == `SPAS_PT_THREAD) ? 3'b000 : rwx;
        next_thread_clear = (pt == `SPAS_PT_THREAD);
        next_hash_block = {368'h0, pt, 5'h0,
                           (pt == `SPAS_PT_THREAD) ? 3'b000 : rwx,
                           32'h0, lin - base, `SPAS_HASH_TAG};
        next_hash_valid = 1'b1;
        next_count = count + 32'h1;
        next_map_we = 1'b1;
        next_done = 1'b1;
        next_state = spas_pkg::S_DONE;
      end
      default: begin
        next_state = spas_pkg::S_IDLE;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= spas_pkg::S_IDLE;
      kind <= spas_pkg::FK_NONE;
      done <= 1'b0;
      fault_addr <= 32'h0;
      count <= 32'h0;
      copy_req <= 1'b0;
      thread_clear <= 1'b0;
      hash_valid <= 1'b0;
      map_we <= 1'b0;
      exit_req <= 1'b0;
      hash_block <= 512'h0;
      map_rwx <= 3'h0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      done <= next_done;
      fault_addr <= next_fault_addr;
      count <= next_count;
      copy_req <= next_copy_req;
      thread_clear <= next_thread_clear;
      hash_valid <= next_hash_valid;
      map_we <= next_map_we;
      exit_req <= next_exit_req;
      hash_block <= next_hash_block;
      map_rwx <= next_map_rwx;
    end
  end

  // operands are flops and these outputs come straight from them or constants, so the map fields are stable
  assign copy_src = src;
  assign copy_dst = target;
  assign map_lin_addr = lin;
  assign map_owner = ctl;
  assign map_type = pt;
  assign exit_qual = `SPAS_CONFLICT_QUAL;
  assign exit_error = `SPAS_EXIT_ERROR;
  assign exit_gla = target;

  // apb slave: zero wait states; writes land at the access edge, reads are fetched at setup
  always_comb begin
    logic busy;
    busy = (state != spas_pkg::S_IDLE) && (state != spas_pkg::S_DONE);
    mapped = (paddr <= `SPAS_COUNT) && (paddr[1:0] == 2'b00);
    next_desc = desc;
    next_target = target;
    next_src = src;
    next_ctl = ctl;
    next_sinfo_addr = sinfo_addr;
    next_lin = lin;
    next_sinfo = sinfo;
    next_env = env;
    next_base = base;
    next_size = size;
    next_limits = limits;
    next_content = content;
    next_token_lo = token_lo;
    next_token_hi = token_hi;
    next_prdata = 32'h0;
    next_pready = psel && !penable;
    next_pslverr = psel && !penable && !mapped;
    if (wr && !busy) begin
      if (paddr == `SPAS_DESC_ADDR) begin
        next_desc = pwdata;
      end else if (paddr == `SPAS_TARGET_ADDR) begin
        next_target = pwdata;
      end else if (paddr == `SPAS_SRC_ADDR) begin
        next_src = pwdata;
      end else if (paddr == `SPAS_CTL_ADDR) begin
        next_ctl = pwdata;
      end else if (paddr == `SPAS_SINFO_ADDR) begin
        next_sinfo_addr = pwdata;
      end else if (paddr == `SPAS_LIN_ADDR) begin
        next_lin = pwdata;
      end else if (paddr == `SPAS_SINFO) begin
        next_sinfo = pwdata;
      end else if (paddr == `SPAS_ENV) begin
        next_env = pwdata;
      end else if (paddr == `SPAS_BASE) begin
        next_base = pwdata;
      end else if (paddr == `SPAS_SIZE) begin
        next_size = pwdata;
      end else if (paddr == `SPAS_LIMITS) begin
        next_limits = pwdata;
      end else if (paddr == `SPAS_CONTENT) begin
        next_content = pwdata;
      end else if (paddr == `SPAS_TOKEN_LO) begin
        next_token_lo = pwdata;
      end else if (paddr == `SPAS_TOKEN_HI) begin
        next_token_hi = pwdata;
      end
    end
    if (rd) begin
      if (paddr == `SPAS_STATUS) begin
        next_prdata = {28'h0, kind, done, busy};
      end else if (paddr == `SPAS_FAULT_ADDR) begin
        next_prdata = fault_addr;
      end else if (paddr == `SPAS_DESC_ADDR) begin
        next_prdata = desc;
      end else if (paddr == `SPAS_TARGET_ADDR) begin
        next_prdata = target;
      end else if (paddr == `SPAS_SRC_ADDR) begin
        next_prdata = src;
      end else if (paddr == `SPAS_CTL_ADDR) begin
        next_prdata = ctl;
      end else if (paddr == `SPAS_SINFO_ADDR) begin
        next_prdata = sinfo_addr;
      end else if (paddr == `SPAS_LIN_ADDR) begin
        next_prdata = lin;
      end else if (paddr == `SPAS_SINFO) begin
        next_prdata = sinfo;
      end else if (paddr == `SPAS_ENV) begin
        next_prdata = env;
      end else if (paddr == `SPAS_BASE) begin
        next_prdata = base;
      end else if (paddr == `SPAS_SIZE) begin
        next_prdata = size;
      end else if (paddr == `SPAS_LIMITS) begin
        next_prdata = limits;
      end else if (paddr == `SPAS_CONTENT) begin
        next_prdata = content;
      end else if (paddr == `SPAS_TOKEN_LO) begin
        next_prdata = token_lo;
      end else if (paddr == `SPAS_TOKEN_HI) begin
        next_prdata = token_hi;
      end else if (paddr == `SPAS_COUNT) begin
        next_prdata = count;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      desc <= 32'h0;
      target <= 32'h0;
      src <= 32'h0;
      ctl <= 32'h0;
      sinfo_addr <= 32'h0;
      lin <= 32'h0;
      sinfo <= 32'h0;
      env <= 32'h0;
      base <= 32'h0;
      size <= 32'h0;
      limits <= 32'h0;
      content <= 32'h0;
      token_lo <= 32'h0;
      token_hi <= 32'h0;
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      desc <= next_desc;
      target <= next_target;
      src <= next_src;
      ctl <= next_ctl;
      sinfo_addr <= next_sinfo_addr;
      lin <= next_lin;
      sinfo <= next_sinfo;
      env <= next_env;
      base <= next_base;
      size <= next_size;
      limits <= next_limits;
      content <= next_content;
      token_lo <= next_token_lo;
      token_hi <= next_token_hi;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  desc_align_a: assert property (state == spas_pkg::S_CHECK && desc[4:0] != 5'h0 |=>
    kind == spas_pkg::FK_PROT && done && state == spas_pkg::S_DONE)
    else $error("misaligned descriptor not faulted");
  tgt_align_a: assert property (state == spas_pkg::S_CHECK && desc[4:0] == 5'h0
    && target[11:0] != 12'h0 |=> kind == spas_pkg::FK_PROT)
    else $error("misaligned target not faulted");
  cache_miss_a: assert property (state == spas_pkg::S_CHECK
    && ck_kind == spas_pkg::FK_PAGING |=> fault_addr == $past(ck_addr) && kind == $past(ck_kind))
    else $error("paging fault address wrong");
  shadow_en_a: assert property (state == spas_pkg::S_CHECK && is_ss
    && !env[`SPAS_ENV_SS_EN] |-> ck_kind != spas_pkg::FK_NONE)
    else $error("shadow page accepted with shadow stacks off");
  exit_pulse_a: assert property (exit_req |-> kind == spas_pkg::FK_EXIT
    && exit_gla == target ##1 !exit_req)
    else $error("exit pulse malformed");
  fault_quiet_a: assert property (state == spas_pkg::S_CHECK
    && ck_kind != spas_pkg::FK_NONE |=> !copy_req [*3])
    else $error("copy after a failed check");
  range_chk_a: assert property (state == spas_pkg::S_CHECK && lin < base
    |-> ck_kind != spas_pkg::FK_NONE)
    else $error("linear address below base accepted");
  copy_first_a: assert property (copy_req |-> ##[2:1000] map_we)
    else $error("copy not followed by commit");
  count_step_a: assert property (hash_valid |-> count == $past(count) + 32'h1
    && map_we && hash_block[63:0] == `SPAS_HASH_TAG)
    else $error("digest update out of step");
  thread_perm_a: assert property (map_we && map_type == `SPAS_PT_THREAD
    |-> map_rwx == 3'b000 && thread_clear)
    else $error("thread page kept permissions");
  commit_src_a: assert property (map_we |-> $past(state) == spas_pkg::S_COMMIT
    && kind == spas_pkg::FK_NONE)
    else $error("map written outside commit");
endmodule

// ### tb/test_secure_page_add_sequencer.sv
/*
  Self-checking bench for the secure page add sequencer: loads operands over
  APB, starts each add, plays the copy engine and checks every result, the fault
  address for paging faults only, against a behavioural model. Assumes the register map of spas_consts.svh.
*/
`timescale 1ns/10ps
`include "spas_consts.svh"

module test_secure_page_add_sequencer;
  localparam int DSC = 3, TGT = 4, SRC = 5, CTL = 6, SIA = 7, LIN = 8, SI = 9, ENV = 10;
  localparam int BAS = 11, SZ = 12, LIM = 13, CON = 14, TKL = 15, TKH = 16, NROW = 35;
  // one row per scenario: two (index, xor mask) edits of the good operand set
  localparam int T1 [NROW] = '{9, 3, 4, 10, 5, 7, 8, 10, 9, 9, 9, 9, 10, 10, 10, 10, 10, 10,
    9, 9, 9, 9, 9, 9, 9, 9, 9, 9, 9, 9, 9, 8, 8, 10, 10};
  localparam logic [31:0] M1 [NROW] = '{32'h0, 32'h10, 32'h800, 32'h800, 32'h4, 32'h20,
    32'h10, 32'h1000, 32'h10000, 32'h100, 32'h700, 32'h700, 32'h10, 32'h14, 32'h20, 32'h40,
    32'h80, 32'h1000000, 32'h300, 32'h300, 32'h300, 32'h300, 32'h1, 32'h600, 32'h700,
    32'h700, 32'h700, 32'h700, 32'h600, 32'h700, 32'h704, 32'h10000000, 32'h13000, 32'h100,
    32'h200};
  localparam int T2 [NROW] = '{0, 0, 0, 0, 0, 0, 0, 0, 0, 0, 10, 10, 0, 0, 0, 0, 0, 0,
    0, 14, 13, 14, 0, 15, 0, 8, 8, 14, 0, 16, 0, 0, 0, 0, 0};
  localparam logic [31:0] M2 [NROW] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h0, 32'h0, 32'h1, 32'h2, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0,
    32'h1, 32'h800, 32'h2, 32'h0, 32'h10004000, 32'h0, 32'h3000, 32'hc000, 32'h4, 32'h0,
    32'h1, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, copy_req;
  logic copy_done = 1'b0;
  logic thread_clear, hash_valid, map_we, exit_req;
  logic [7:0] paddr, map_type;
  logic [31:0] pwdata, prdata, copy_src, copy_dst, map_lin_addr, map_owner, exit_gla;
  logic [511:0] hash_block, exp_blk;
  logic [2:0] map_rwx, exp_rwx;
  logic [15:0] exit_qual, exit_error;
  logic [31:0] cfg [0:16];
  logic [31:0] base_cfg [0:16];
  int err_total, comparisons, n_copy, n_hash, n_map, n_thread, n_exit, dly;

  spas_sequencer i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .copy_done(copy_done), .copy_req(copy_req), .copy_src(copy_src),
    .copy_dst(copy_dst), .thread_clear(thread_clear), .hash_valid(hash_valid),
    .hash_block(hash_block), .map_we(map_we), .map_lin_addr(map_lin_addr),
    .map_owner(map_owner), .map_type(map_type), .map_rwx(map_rwx), .exit_req(exit_req),
    .exit_qual(exit_qual), .exit_error(exit_error), .exit_gla(exit_gla));

  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  task automatic check(input string name, input logic [511:0] seen, input logic [511:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("FAIL %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  // copy engine stand-in: answers each request after a random latency
  always @(posedge ref_clk) begin
    copy_done <= (dly == 1);
    if (dly > 0) begin
      dly <= dly - 1;
    end
    if (copy_req === 1'b1) begin
      n_copy++;
      dly <= 1 + int'($urandom % 6);
      check("copy_src", copy_src, cfg[SRC]);
      check("copy_dst", copy_dst, cfg[TGT]);
    end
    if (hash_valid === 1'b1) begin
      n_hash++;
      check("hash_block", hash_block, exp_blk);
    end
    if (map_we === 1'b1) begin
      n_map++;
      check("map_lin_addr", map_lin_addr, cfg[LIN]);
      check("map_owner", map_owner, cfg[CTL]);
      check("map_type", map_type, cfg[SI][15:8]);
      check("map_rwx", map_rwx, exp_rwx);
    end
    if (thread_clear === 1'b1) n_thread++;
    if (exit_req === 1'b1) begin
      n_exit++;
      check("exit_qual", exit_qual, `SPAS_CONFLICT_QUAL);
      check("exit_error", exit_error, `SPAS_EXIT_ERROR);
      check("exit_gla", exit_gla, cfg[TGT]);
    end
  end

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge ref_clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      err_total++;
      report_and_stop();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge, so a following call never re-drives psel in this time step
    @(posedge ref_clk);
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    logic e;
    apb(1'b0, a, 32'h0, q, e);
  endtask

  // expected outcome of one add, in the order the checks are made
  function automatic int model(output logic [31:0] fa);
    logic [31:0] e, s, l, c;
    logic [7:0] pt;
    logic ss;
    longint lin, bs, top, tok;
    e = cfg[ENV];
    s = cfg[SI];
    l = cfg[LIM];
    c = cfg[CON];
    pt = s[15:8];
    ss = (pt == `SPAS_TYPE_SHADOW_FIRST) || (pt == `SPAS_TYPE_SHADOW_REST);
    lin = cfg[LIN];
    bs = cfg[BAS];
    top = bs + cfg[SZ];
    tok = {cfg[TKH], cfg[TKL]};
    fa = cfg[TGT];
    if (cfg[DSC][4:0] != 0) return 1;
    if (cfg[TGT][11:0] != 0) return 1;
    if (!e[`SPAS_ENV_TGT_IN_PPC]) return 2;
    if (cfg[SRC][11:0] || cfg[CTL][11:0] || cfg[LIN][11:0] || cfg[SIA][5:0]) return 1;
    fa = cfg[CTL];
    if (!e[`SPAS_ENV_CTL_IN_PPC]) return 2;
    if (s[`SPAS_SI_RSVD] || !(pt == `SPAS_PT_THREAD || pt == `SPAS_PT_REGULAR ||
        (ss && e[`SPAS_ENV_SS_CAP]))) return 1;
    if (ss && !e[`SPAS_ENV_SS_EN]) return 1;
    if (e[`SPAS_ENV_IN_USE]) return e[`SPAS_ENV_VIRT] ? 3 : 1;
    fa = cfg[TGT];
    if (e[`SPAS_ENV_TGT_VALID]) return 2;
    if (e[`SPAS_ENV_CTL_BUSY]) return 1;
    fa = cfg[CTL];
    if (!e[`SPAS_ENV_CTL_VALID] || e[31:24] != `SPAS_PT_CONTROL) return 2;
    if (pt == `SPAS_PT_THREAD && (c[`SPAS_CT_THREAD_RSVD] || (!e[`SPAS_ENV_WIDE] &&
        (l[11:0] != `SPAS_LIMIT_ONES || l[27:16] != `SPAS_LIMIT_ONES)) ||
        (e[`SPAS_ENV_SS_SUP] && c[`SPAS_CT_PREV_SSP]))) return 1;
    if (pt == `SPAS_PT_REGULAR && s[`SPAS_SI_W] && !s[`SPAS_SI_R]) return 1;
    if (ss) begin
      if (lin == bs || lin == top - `SPAS_PAGE) return 1;
      if (c[`SPAS_CT_SS_LOW]) return 1;
      if (tok != ((pt == `SPAS_TYPE_SHADOW_FIRST) ? ((lin + `SPAS_PAGE) | e[`SPAS_ENV_WIDE]) : 0))
        return 1;
      if (!s[`SPAS_SI_R] || !s[`SPAS_SI_W] || s[`SPAS_SI_X]) return 1;
    end
    if (lin < bs || lin >= top) return 1;
    if (e[`SPAS_ENV_MEAS_BUSY] || e[`SPAS_ENV_INIT]) return 1;
    return 0;
  endfunction

  task automatic run_op();
    logic [31:0] st, fa, fexp, cnt0, cnt1;
    logic [7:0] pt;
    int k, n;
    for (int i = DSC; i <= TKH; i++) wr(8'(i * 4), cfg[i]);
    k = model(fexp);
    pt = cfg[SI][15:8];
    exp_rwx = (pt == `SPAS_PT_THREAD) ? 3'b000 : cfg[SI][2:0];
    exp_blk = {368'h0, pt, 5'h0, exp_rwx, 32'h0, cfg[LIN] - cfg[BAS], `SPAS_HASH_TAG};
    rd(`SPAS_COUNT, cnt0);
    n_copy = 0;
    n_hash = 0;
    n_map = 0;
    n_thread = 0;
    n_exit = 0;
    wr(`SPAS_CTRL, 32'h1);
    n = 0;
    do begin
      rd(`SPAS_STATUS, st);
      n++;
    end while (st[1] !== 1'b1 && n < 40);
    if (n >= 40) begin
      err_total++;
      report_and_stop();
    end
    rd(`SPAS_FAULT_ADDR, fa);
    rd(`SPAS_COUNT, cnt1);
    check("status", st, {28'h0, k[1:0], 2'b10});
    if (k == 2) check("fault_addr", fa, fexp);
    check("count", cnt1, cnt0 + (k == 0));
    check("copies", n_copy, k == 0);
    check("hashes", n_hash, k == 0);
    check("commits", n_map, k == 0);
    check("thread_clears", n_thread, k == 0 && pt == `SPAS_PT_THREAD);
    check("exits", n_exit, k == 3);
  endtask

  initial begin
    logic [31:0] q;
    logic e;
    int r;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    rst_n = 1'b0;
    base_cfg = '{32'h0, 32'h0, 32'h0, 32'h100, 32'h200000, 32'h300000, 32'h400000, 32'h140,
      32'h10003000, 32'h203, 32'h188b, 32'h10000000, 32'h10000, 32'hfff0fff, 32'h0, 32'h0,
      32'h0};
    cfg = base_cfg;
    void'($urandom(32'hf6761a73));
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    @(posedge ref_clk);
    rd(`SPAS_STATUS, q);
    check("status_reset", q, 32'h0);
    apb(1'b0, 8'h48, 32'h0, q, e);
    check("unmapped_err", e, 1'b1);
    check("unmapped_data", q, 32'h0);
    // table rows first, then random rows with one environment bit flipped
    for (int i = 0; i < NROW + 25; i++) begin
      r = (i < NROW) ? i : int'($urandom % NROW);
      cfg = base_cfg;
      cfg[T1[r]] ^= M1[r];
      cfg[T2[r]] ^= M2[r];
      if (i >= NROW) cfg[ENV] ^= 32'h1 << ($urandom % 13);
      run_op();
    end
    report_and_stop();
  end
endmodule
